// >>> exec_cost_unit.sv
`timescale 1ns/100ps
module exec_cost_unit
  import exec_timing_pkg::*;
(
  input wire logic CLK_SYS, // system clock, 250 MHz
  input wire logic RST, // asynchronous reset, active high
  input wire logic CYC_I, // bus cycle
  input wire logic STB_I, // bus strobe
  input wire logic WE_I, // write enable
  input wire logic [7:0] ADR_I, // byte address
  input wire logic [3:0] SEL_I, // byte lane selects
  input wire logic [31:0] DAT_I, // write data
  output logic [31:0] DAT_O, // read data
  output logic ACK_O, // bus acknowledge
  output logic EXEC_BUSY // execution window running
);

  logic [15:0] instr_q;
  logic [15:0] target_q;
  logic [31:0] ctrl_q;
  logic start_pulse;
  logic done_q;
  logic [CW-1:0] cyc_q;
  logic [MW-1:0] acc_q;
  logic [TW-1:0] total_q;
  logic [3:0] w_q;
  logic bus_req;
  logic wr_take;
  logic [31:0] rd_data;
  cost_type base_i;
  cost_type base_t;
  logic [CW-1:0] next_c;
  logic [MW-1:0] next_m;
  logic [TW-1:0] next_total;
  logic [1:0] mode_sel [4];
  logic [3:0] reg_sel [4];
  set_type set_sel [4];
  logic [CW-1:0] op_c [4];
  logic [MW-1:0] op_m [4];
  logic [TW-1:0] remain;
  logic tdone;
  seq_type seq;
  logic [3:0] wait_st;

  function automatic cost_type mk(input logic [CW-1:0] c,
                                  input logic [MW-1:0] m,
                                  input set_type s,
                                  input set_type d);
    cost_type r;
    r.c = c;
    r.m = m;
    r.src = s;
    r.dst = d;
    r.is_x = 1'b0;
    return r;
  endfunction : mk

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge

  // cost of one opcode word with all operands in register mode
  function automatic cost_type base_cost(input logic [15:0] op,
                                         input logic ovf,
                                         input logic jmp,
                                         input logic msb,
                                         input logic [3:0] wr0,
                                         input logic [5:0] steps);
    cost_type r;
    set_type bs;
    logic [3:0] crc;
    logic [3:0] cnt;
    logic [5:0] st;
    r = mk(UNDEF_C, UNDEF_M, SET_NONE, SET_NONE);
    bs = op[12] ? SET_B : SET_A;
    crc = op[9:6];
    cnt = op[7:4];
    st = (steps > DIV_STEPS_MAX) ? DIV_STEPS_MAX : steps;
    if (op[15:14] != 2'h0)
      r = mk(8'h0E, (op[15:13] == 3'h4) ? 5'h03 : 5'h04, bs, bs);
    else if (op[13])
    begin
      unique case (op[12:10])
        3'h0, 3'h1: r = mk(8'h0E, 5'h03, SET_A, SET_NONE);
        3'h2: r = mk(8'h0E, 5'h04, SET_A, SET_NONE);
        3'h3: r = mk(8'h24, 5'h08, SET_A, SET_NONE);
        3'h4:
          if (crc == 4'h0)
            r = mk(8'h34, 5'h03, SET_A, SET_NONE);
          else
            r = mk(8'h14 + {3'h0, crc, 1'b0}, 5'h03,
                   (crc <= 4'h8) ? SET_B : SET_A, SET_NONE);
        3'h5:
          if (crc == 4'h0)
            r = mk(8'h3C, 5'h04, SET_A, SET_NONE);
          else if (crc <= 4'h7)
            r = mk(8'h2A, 5'h04, SET_B, SET_NONE);
          else if (crc == 4'h8)
            r = mk(8'h2C, 5'h04, SET_B, SET_NONE);
          else
            r = mk(8'h3A, 5'h04, SET_A, SET_NONE);
        3'h6: r = mk(8'h34, 5'h05, SET_A, SET_NONE);
        3'h7:
          // exact divide length follows the partial quotients
          r = ovf ? mk(DIV_OVF_C, DIV_OVF_M, SET_A, SET_NONE)
                  : mk(DIV_C + {2'h0, st}, DIV_M, SET_A, SET_NONE);
      endcase
    end
    else if (op[12])
    begin
      if (op[11:8] >= 4'hD)
        r = mk(8'h0C, 5'h02, SET_NONE, SET_NONE);
      else
        r = mk(jmp ? 8'h0A : 8'h08, 5'h01, SET_NONE, SET_NONE);
    end
    else if (op[11:10] == 2'h2)
    begin
      if (cnt != 4'h0)
        r = mk(SHIFT_C + {3'h0, cnt, 1'b0}, 5'h03, SET_NONE, SET_NONE);
      else if (wr0 == 4'h0)
        r = mk(SHIFT_WR0_C + {2'h0, SHIFT_FULL, 1'b0}, 5'h04,
               SET_NONE, SET_NONE);
      else
        r = mk(SHIFT_WR0_C + {3'h0, wr0, 1'b0}, 5'h04,
               SET_NONE, SET_NONE);
    end
    else if (op[11:10] == 2'h1)
    begin
      unique case (op[9:6])
        4'h0: r = mk(8'h1A, 5'h06, SET_A, SET_NONE);
        4'h1: r = mk(8'h08, 5'h02, SET_A, SET_NONE);
        4'h2:
        begin
          r = mk(8'h08, 5'h02, SET_A, SET_NONE);
          r.is_x = 1'b1;
        end
        4'h4, 4'hA: r = mk(8'h0C, 5'h03, SET_A, SET_NONE);
        4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC:
          r = mk(8'h0A, 5'h03, SET_A, SET_NONE);
        4'hD: r = msb ? mk(8'h0E, 5'h03, SET_A, SET_NONE)
                      : mk(8'h0C, 5'h02, SET_A, SET_NONE);
        4'hE, 4'hF: r = mk(UNDEF_C, UNDEF_M, SET_NONE, SET_NONE);
      endcase
    end
    else if (op[11:9] == 3'h1)
    begin
      unique case (op[8:5])
        4'h0: r = mk(8'h0C, 5'h03, SET_NONE, SET_NONE);
        4'h1, 4'h2, 4'h3, 4'hC: r = mk(8'h0E, 5'h04, SET_NONE, SET_NONE);
        4'h4: r = mk(8'h0E, 5'h03, SET_NONE, SET_NONE);
        4'h5, 4'h6: r = mk(8'h08, 5'h02, SET_NONE, SET_NONE);
        4'h7: r = mk(8'h0A, 5'h02, SET_NONE, SET_NONE);
        4'h8: r = mk(8'h10, 5'h02, SET_NONE, SET_NONE);
        4'h9: r = mk(UNDEF_C, UNDEF_M, SET_NONE, SET_NONE);
        4'hA, 4'hB, 4'hD, 4'hE, 4'hF:
          r = mk(8'h0C, 5'h01, SET_NONE, SET_NONE);
      endcase
    end
    return r;
  endfunction : base_cost

  assign seq = seq_type'(ctrl_q[CTRL_SEQ +: 2]);
  assign wait_st = ctrl_q[CTRL_WAIT +: 4];
  assign bus_req = CYC_I & STB_I;
  assign wr_take = bus_req & WE_I & ACK_O;

  always_comb
  begin
    base_i = base_cost(instr_q, ctrl_q[CTRL_OVF], ctrl_q[CTRL_JMP],
                       ctrl_q[CTRL_MSB], ctrl_q[CTRL_WR0 +: 4],
                       ctrl_q[CTRL_DIV +: 6]);
    base_t = base_cost(target_q, ctrl_q[CTRL_OVF], ctrl_q[CTRL_JMP],
                       ctrl_q[CTRL_MSB], ctrl_q[CTRL_WR0 +: 4],
                       ctrl_q[CTRL_DIV +: 6]);
  end

  always_comb
  begin
    mode_sel[0] = instr_q[5:4];
    reg_sel[0] = instr_q[3:0];
    set_sel[0] = base_i.src;
    mode_sel[1] = instr_q[11:10];
    reg_sel[1] = instr_q[9:6];
    set_sel[1] = base_i.dst;
    mode_sel[2] = target_q[5:4];
    reg_sel[2] = target_q[3:0];
    set_sel[2] = base_t.src;
    mode_sel[3] = target_q[11:10];
    reg_sel[3] = target_q[9:6];
    set_sel[3] = base_t.dst;
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_op
    operand_cost u_op (
      .mode(mode_sel[g]),
      .reg_num(reg_sel[g]),
      .cost_set(set_sel[g]),
      .extra_c(op_c[g]),
      .extra_m(op_m[g])
    );
  end

  always_comb
  begin
    next_c = base_i.c + op_c[0] + op_c[1];
    next_m = base_i.m + op_m[0] + op_m[1];
    unique case (seq)
      SEQ_RESET:
      begin
        next_c = RESET_SEQ_C;
        next_m = RESET_SEQ_M;
      end
      SEQ_LOAD, SEQ_INTR:
      begin
        next_c = LOAD_SEQ_C;
        next_m = LOAD_SEQ_M;
      end
      SEQ_INSTR:
        // a target that is itself an execute is costed flat, no nesting
        if (base_i.is_x)
        begin
          next_c = next_c + base_t.c + op_c[2] + op_c[3] - X_ADJ_C;
          next_m = next_m + base_t.m + op_m[2] + op_m[3] - X_ADJ_M;
        end
    endcase
    next_total = TW'(next_c) + TW'(wait_st) * TW'(next_m);
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      instr_q <= 16'h0000;
      target_q <= 16'h0000;
      ctrl_q <= CTRL_RESET;
    end
    else if (wr_take)
    begin
      if (ADR_I == OFS_INSTR)
        instr_q <= 16'(merge({16'h0000, instr_q}, DAT_I, SEL_I));
      if (ADR_I == OFS_TARGET)
        target_q <= 16'(merge({16'h0000, target_q}, DAT_I, SEL_I));
      if (ADR_I == OFS_CTRL)
        ctrl_q <= merge(ctrl_q, DAT_I, SEL_I) & CTRL_MASK;
    end
  end

  // start is a self-clearing command; costs settle one cycle after the write
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      start_pulse <= 1'b0;
    else
      start_pulse <= wr_take && ADR_I == OFS_CTRL && SEL_I[0]
                     && DAT_I[CTRL_START];
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cyc_q <= '0;
      acc_q <= '0;
      total_q <= '0;
      w_q <= 4'h0;
    end
    else if (start_pulse)
    begin
      cyc_q <= next_c;
      acc_q <= next_m;
      total_q <= next_total;
      w_q <= wait_st;
    end
  end

  // completion wins over a start in the same cycle so no end is lost
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      done_q <= 1'b0;
    else if (tdone)
      done_q <= 1'b1;
    else if (start_pulse)
      done_q <= 1'b0;
  end

  exec_timer u_timer (
    .clk(CLK_SYS),
    .rst(RST),
    .load(start_pulse),
    .total(next_total),
    .busy(EXEC_BUSY),
    .remain(remain),
    .done(tdone)
  );

  always_comb
  begin
    unique case (ADR_I)
      OFS_INSTR: rd_data = {16'h0000, instr_q};
      OFS_TARGET: rd_data = {16'h0000, target_q};
      OFS_CTRL: rd_data = ctrl_q;
      OFS_STATUS: rd_data = {30'h0000_0000, done_q, EXEC_BUSY};
      OFS_CYCLES: rd_data = {24'h00_0000, cyc_q};
      OFS_ACCESS: rd_data = {27'h000_0000, acc_q};
      OFS_TOTAL: rd_data = {20'h0_0000, total_q};
      OFS_REMAIN: rd_data = {20'h0_0000, remain};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h0000_0000;
    end
    else
    begin
      ACK_O <= bus_req & ~ACK_O;
      if (bus_req && !ACK_O && !WE_I)
        DAT_O <= rd_data;
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  sequence s_start;
    start_pulse ##0 next_total != '0;
  endsequence

  chk_total_formula: assert property (
    start_pulse |=> total_q == TW'(cyc_q) + TW'(w_q) * TW'(acc_q))
    else $error("total does not equal C plus W times M");

  chk_window_length: assert property (
    s_start |=> EXEC_BUSY && remain == $past(next_total))
    else $error("execution window not loaded with the total");

  chk_base_regmode: assert property (
    start_pulse && seq == SEQ_INSTR && !base_i.is_x
    && instr_q[5:4] == MODE_REG && instr_q[11:10] == MODE_REG
    |=> cyc_q == $past(base_i.c) && acc_q == $past(base_i.m))
    else $error("register-mode cost differs from base cost");

  chk_operand_sum: assert property (
    start_pulse && seq == SEQ_INSTR && !base_i.is_x
    |=> cyc_q == $past(base_i.c + op_c[0] + op_c[1]))
    else $error("operand costs not added to base");

  chk_indirect_cost: assert property (
    mode_sel[0] == MODE_IND && set_sel[0] != SET_NONE
    |-> op_c[0] == 8'h04 && op_m[0] == 5'h01)
    else $error("indirect operand cost wrong");

  chk_autoinc_a: assert property (
    mode_sel[1] == MODE_AUTO && set_sel[1] == SET_A
    |-> op_c[1] == 8'h08 && op_m[1] == 5'h02)
    else $error("auto-increment cost wrong in set A");

  chk_autoinc_b: assert property (
    mode_sel[0] == MODE_AUTO && set_sel[0] == SET_B
    |-> op_c[0] == 8'h06 && op_m[0] == 5'h02)
    else $error("auto-increment cost wrong in set B");

  chk_symbolic_cost: assert property (
    mode_sel[0] == MODE_SYM && reg_sel[0] == 4'h0 && set_sel[0] != SET_NONE
    |-> op_c[0] == 8'h08 && op_m[0] == 5'h01)
    else $error("symbolic operand cost wrong");

  chk_indexed_cost: assert property (
    mode_sel[1] == MODE_SYM && reg_sel[1] != 4'h0 && set_sel[1] != SET_NONE
    |-> op_c[1] == 8'h08 && op_m[1] == 5'h02)
    else $error("indexed operand cost wrong");

  chk_divide_cost: assert property (
    instr_q[15:10] == 6'h0F
    |-> ctrl_q[CTRL_OVF] ? (base_i.c == 8'h10 && base_i.m == 5'h03)
      : (base_i.c >= 8'h5C && base_i.c <= 8'h7C && base_i.m == 5'h06))
    else $error("divide cost out of range");

  chk_execute_adds: assert property (
    start_pulse && seq == SEQ_INSTR && base_i.is_x
    |=> cyc_q == $past(base_i.c + op_c[0] + base_t.c + op_c[2]
                       + op_c[3] - 8'h04))
    else $error("execute-at-address cost not merged with target");

  chk_shift_wr0: assert property (
    instr_q[15:10] == 6'h02 && instr_q[7:4] == 4'h0
    && ctrl_q[CTRL_WR0 +: 4] == 4'h0 |-> base_i.c == 8'h34)
    else $error("zero shift count not taken as sixteen");

  chk_undefined_op: assert property (
    instr_q[15:9] == 7'h00 || instr_q[15:10] == 6'h03
    |-> base_i.c == 8'h06 && base_i.m == 5'h01 && base_i.src == SET_NONE)
    else $error("undefined opcode cost wrong");

  chk_seq_cost: assert property (
    start_pulse && seq == SEQ_RESET |=> cyc_q == 8'h1A && acc_q == 5'h05)
    else $error("reset sequence cost wrong");

endmodule : exec_cost_unit

// >>> exec_timing_pkg.sv
package exec_timing_pkg;

  localparam int CW = 8;
  localparam int MW = 5;
  localparam int TW = 12;

  // register byte addresses
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_CYCLES = 8'h10;
  localparam logic [7:0] OFS_ACCESS = 8'h14;
  localparam logic [7:0] OFS_TOTAL = 8'h18;
  localparam logic [7:0] OFS_REMAIN = 8'h1C;

  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_SEQ = 1;
  localparam int CTRL_OVF = 3;
  localparam int CTRL_JMP = 4;
  localparam int CTRL_MSB = 5;
  localparam int CTRL_WAIT = 6;
  localparam int CTRL_WR0 = 10;
  localparam int CTRL_DIV = 14;
  localparam logic [31:0] CTRL_MASK = 32'h000F_FFFE;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // operand mode field encodings
  localparam logic [1:0] MODE_REG = 2'h0;
  localparam logic [1:0] MODE_IND = 2'h1;
  localparam logic [1:0] MODE_SYM = 2'h2;
  localparam logic [1:0] MODE_AUTO = 2'h3;

  // extra cost of modified addressing
  localparam logic [CW-1:0] IND_C = 8'h04;
  localparam logic [MW-1:0] IND_M = 5'h01;
  localparam logic [CW-1:0] AUTO_A_C = 8'h08;
  localparam logic [CW-1:0] AUTO_B_C = 8'h06;
  localparam logic [MW-1:0] AUTO_M = 5'h02;
  localparam logic [CW-1:0] SYM_C = 8'h08;
  localparam logic [MW-1:0] SYM_M = 5'h01;
  localparam logic [CW-1:0] IDX_C = 8'h08;
  localparam logic [MW-1:0] IDX_M = 5'h02;

  // fixed sequences and special instructions
  localparam logic [CW-1:0] RESET_SEQ_C = 8'h1A;
  localparam logic [MW-1:0] RESET_SEQ_M = 5'h05;
  localparam logic [CW-1:0] LOAD_SEQ_C = 8'h16;
  localparam logic [MW-1:0] LOAD_SEQ_M = 5'h05;
  localparam logic [CW-1:0] UNDEF_C = 8'h06;
  localparam logic [MW-1:0] UNDEF_M = 5'h01;
  localparam logic [CW-1:0] DIV_OVF_C = 8'h10;
  localparam logic [MW-1:0] DIV_OVF_M = 5'h03;
  localparam logic [CW-1:0] DIV_C = 8'h5C;
  localparam logic [MW-1:0] DIV_M = 5'h06;
  localparam logic [5:0] DIV_STEPS_MAX = 6'h20;
  localparam logic [CW-1:0] X_ADJ_C = 8'h04;
  localparam logic [MW-1:0] X_ADJ_M = 5'h01;
  localparam logic [CW-1:0] SHIFT_C = 8'h0C;
  localparam logic [CW-1:0] SHIFT_WR0_C = 8'h14;
  localparam logic [4:0] SHIFT_FULL = 5'h10;

  typedef enum logic [1:0] {SET_NONE, SET_A, SET_B} set_type;
  typedef enum logic [1:0] {SEQ_INSTR, SEQ_RESET, SEQ_LOAD, SEQ_INTR} seq_type;

  typedef struct packed {
    logic [CW-1:0] c;
    logic [MW-1:0] m;
    set_type src;
    set_type dst;
    logic is_x;
  } cost_type;

endpackage : exec_timing_pkg

// >>> operand_cost.sv
`timescale 1ns/100ps
module operand_cost
  import exec_timing_pkg::*;
(
  input wire logic [1:0] mode, // operand mode field
  input wire logic [3:0] reg_num, // operand register number
  input wire set_type cost_set, // which cost set applies
  output logic [CW-1:0] extra_c, // extra clock cycles
  output logic [MW-1:0] extra_m // extra memory accesses
);

  always_comb
  begin
    extra_c = '0;
    extra_m = '0;
    if (cost_set != SET_NONE)
    begin
      unique case (mode)
        MODE_REG:
        begin
          extra_c = '0;
          extra_m = '0;
        end
        MODE_IND:
        begin
          extra_c = IND_C;
          extra_m = IND_M;
        end
        MODE_AUTO:
        begin
          // byte operands step the register by one, which is cheaper
          extra_c = (cost_set == SET_B) ? AUTO_B_C : AUTO_A_C;
          extra_m = AUTO_M;
        end
        MODE_SYM:
        begin
          extra_c = (reg_num == 4'h0) ? SYM_C : IDX_C;
          extra_m = (reg_num == 4'h0) ? SYM_M : IDX_M;
        end
      endcase
    end
  end

endmodule : operand_cost

// >>> exec_timer.sv
`timescale 1ns/100ps
module exec_timer
  import exec_timing_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic load, // start a new execution window
  input wire logic [TW-1:0] total, // cycles the window lasts
  output logic busy, // window in progress
  output logic [TW-1:0] remain, // cycles left in the window
  output logic done // one-cycle pulse at window end
);

  typedef enum logic {T_IDLE, T_RUN} tstate_type;
  tstate_type state;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state <= T_IDLE;
      busy <= 1'b0;
      remain <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load && total != '0)
      begin
        state <= T_RUN;
        busy <= 1'b1;
        remain <= total;
      end
      else
      begin
        unique case (state)
          T_IDLE:
            busy <= 1'b0;
          T_RUN:
            if (remain == TW'(1))
            begin
              state <= T_IDLE;
              busy <= 1'b0;
              remain <= '0;
              done <= 1'b1;
            end
            else
              remain <= remain - TW'(1);
        endcase
      end
    end
  end

  chk_count_down: assert property (@(posedge clk) disable iff (rst)
    busy && !load && remain > TW'(1) |=> busy && remain == $past(remain) - TW'(1))
    else $error("window counter did not step down by one");

  chk_window_end: assert property (@(posedge clk) disable iff (rst)
    busy && !load && remain == TW'(1) |=> done && !busy)
    else $error("window did not close after its last cycle");

endmodule : exec_timer

// >>> mem_wait_model.sv
`timescale 1ns/100ps
module mem_wait_model (
  input wire logic clk, // system clock
  input wire logic busy, // instruction in progress
  output logic [3:0] wait_states // wait states per memory access
);
  int seed = 11;
  logic busy_q = 1'b0;
  // starts prompt, then memory latency wanders between instructions
  logic [3:0] ws = 4'h0;
  assign wait_states = ws;
  always @(posedge clk)
  begin
    busy_q <= busy;
    if (busy_q && !busy)
      ws <= 4'($random(seed));
  end
endmodule : mem_wait_model

// >>> test_exec_cost_unit.sv
`timescale 1ns/100ps
`define CHECK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
  end
module test_exec_cost_unit import exec_timing_pkg::*;;
  logic CLK_SYS, RST, CYC_I, STB_I, WE_I, ACK_O, EXEC_BUSY;
  logic [7:0] ADR_I;
  logic [3:0] SEL_I, wait_states;
  logic [31:0] DAT_I, DAT_O, rd, r, r2;
  logic [51:0] corner [19] = '{
    52'h0740_0000_00020, 52'h0750_0000_00000,
    52'h0000_0000_00000, 52'h01FE_0000_00000, 52'h0000_0000_00002,
    52'h0000_0000_00004, 52'h0000_0000_00006, 52'h0A00_0000_00000,
    52'h0800_0000_03C00, 52'h0BF3_0000_00000, 52'h3C00_0000_00008,
    52'h3C31_0000_80000, 52'h3C00_0000_A0000, 52'h0480_0200_00000,
    52'hBC30_0000_00000, 52'hAC30_0000_00000, 52'hA820_0000_00000,
    52'hA865_0000_00000, 52'hA410_0000_00010};
  int bad_count = 0;
  int n_tests = 0;
  int seed = 35;
  exec_cost_unit dut (.CLK_SYS(CLK_SYS), .RST(RST), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I),
    .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .EXEC_BUSY(EXEC_BUSY));
  mem_wait_model partner (.clk(CLK_SYS), .busy(EXEC_BUSY),
    .wait_states(wait_states));
  function automatic void add_mode(input logic [1:0] t,
    input logic [3:0] n, input logic b, inout int c, inout int m);
    c += (t == 1) ? 4 : (t == 3) ? (b ? 6 : 8) : (t == 2) ? 8 : 0;
    m += (t == 0) ? 0 : (t == 1) ? 1 : (t == 3 || n != 0) ? 2 : 1;
  endfunction : add_mode
  function automatic void expect_cost(input logic [15:0] i, g,
    input logic [19:0] f, output int c, output int m);
    int n;
    c = 6;
    m = 1;
    if (f[2:1] != 0)
    begin
      c = (f[2:1] == 1) ? 26 : 22;
      m = 5;
    end
    else if (i[15:13] == 3'h5)
    begin
      c = 14;
      m = 4;
      add_mode(i[5:4], i[3:0], i[12], c, m);
      add_mode(i[11:10], i[9:6], i[12], c, m);
    end
    else if (i[15:10] == 6'h02)
    begin
      n = (i[7:4] != 0) ? i[7:4] : f[13:10];
      c = (i[7:4] != 0) ? 12 + 2 * n : (n == 0) ? 52 : 20 + 2 * n;
      m = (i[7:4] != 0) ? 3 : 4;
    end
    else if (i[15:10] == 6'h0F)
    begin
      c = f[3] ? 16 : 92 + ((f[19:14] > 32) ? 32 : f[19:14]);
      m = f[3] ? 3 : 6;
      add_mode(i[5:4], i[3:0], 1'b0, c, m);
    end
    else if (i[15:6] == 10'h012)
    begin
      expect_cost(g, g, f, c, m);
      c += 8 - 4;
      m += 2 - 1;
      add_mode(i[5:4], i[3:0], 1'b0, c, m);
    end
    else if (i[15:6] == 10'h01D)
    begin
      c = f[5] ? 14 : 12;
      m = f[5] ? 3 : 2;
      add_mode(i[5:4], i[3:0], 1'b0, c, m);
    end
    else if (i[15:12] == 4'h1)
      c = f[4] ? 10 : 8;
    else if (i[15:8] == 8'h02)
    begin
      c = (i[7:5] == 0) ? 12 : 14;
      m = (i[7:5] == 0 || i[7:5] == 4) ? 3 : 4;
    end
  endfunction : expect_cost
  task automatic bus(input logic we, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge CLK_SYS);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= a;
    SEL_I <= 4'hF;
    DAT_I <= d;
    // only the watchdog ends a wait for the acknowledge
    do
      @(posedge CLK_SYS);
    while (ACK_O !== 1'b1);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask : bus
  task automatic run(input logic [15:0] i, g, input logic [19:0] f);
    int c, m, t, n, k;
    logic [3:0] w;
    logic [31:0] ctl;
    w = wait_states;
    ctl = {12'h000, f[19:10], w, f[5:1], 1'b1};
    expect_cost(i, g, f, c, m);
    t = c + w * m;
    bus(1'b1, OFS_INSTR, {16'h0000, i});
    bus(1'b1, OFS_TARGET, {16'h0000, g});
    bus(1'b1, OFS_CTRL, ctl);
    n = 0;
    for (k = 0; k < 600; k++)
    begin
      @(posedge CLK_SYS);
      if (EXEC_BUSY === 1'b1)
        n++;
      else if (n > 0)
        break;
    end
    `CHECK(n, t)
    bus(1'b0, OFS_CYCLES, 0);
    `CHECK(rd, 32'(c))
    bus(1'b0, OFS_ACCESS, 0);
    `CHECK(rd, 32'(m))
    bus(1'b0, OFS_TOTAL, 0);
    `CHECK(rd, 32'(t))
    bus(1'b0, OFS_STATUS, 0);
    `CHECK(rd, 32'h2)
    bus(1'b0, OFS_CTRL, 0);
    `CHECK(rd, ctl & CTRL_MASK)
  endtask : run
  task automatic report_and_stop;
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  initial
  begin
    repeat (60000) @(posedge CLK_SYS);
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    RST = 1'b1;
    CYC_I = 1'b0;
    STB_I = 1'b0;
    WE_I = 1'b0;
    ADR_I = 8'h00;
    SEL_I = 4'hF;
    DAT_I = 32'h0000_0000;
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    // 0x20 is unmapped: acked, write dropped, reads zero
    bus(1'b1, 8'h20, 32'hFFFF_FFFF);
    bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF);
    for (int a = 0; a < 36; a += 4)
    begin
      bus(1'b0, 8'(a), 0);
      `CHECK(rd, 32'h0)
    end
    foreach (corner[j])
      run(corner[j][51:36], corner[j][35:20], corner[j][19:0]);
    for (int j = 0; j < 5; j++)
      run({11'h010 + 11'(j), 5'h03}, 16'h0000, 20'h00000);
    for (int j = 0; j < 48; j++)
    begin
      r = $random(seed);
      r2 = $random(seed);
      case (r[2:0])
        3'h0: run({4'hA, r[15:4]}, 16'h0000, {r2[19:3], 3'h0});
        3'h1: run({4'hB, r[15:4]}, 16'h0000, {r2[19:3], 3'h0});
        3'h2: run({6'h02, r[9:0]}, 16'h0000, {r2[19:3], 3'h0});
        3'h3: run({6'h0F, r[9:0]}, 16'h0000, {r2[19:3], 3'h0});
        3'h4: run({10'h012, r[5:0]}, {4'hA, r[27:16]}, 20'h00000);
        3'h5: run({7'h00, r[8:1], 1'b0}, 16'h0000, 20'h00000);
        3'h6: run({5'h02, r[10:0]}, 16'h0000, {r2[19:3], 3'h0});
        default: run({11'h010 + 11'(r[5:4]), r[3:0], 1'b0}, 16'h0000,
          20'h00000);
      endcase
    end
    report_and_stop();
  end
endmodule : test_exec_cost_unit
